// ===== rtl/pidc_defines.svh
// constants for the panel indicator and delay control block
// assumes a 100 MHz clock and a plain register port of the top module
//
// Contract
// R01: routing delay button toggles delay enable, or cancels counting delay and routes now
// R02: routing delay led steady when enabled, flashing while counting; routing on at expiry
// R03: plain routing countdown shows stage one label and remaining seconds
// R04: extended routing countdown shows stage two label and remaining seconds
// R05: routing fault led flashes on fault, steady on disable or test
// R06: protection on button cancels delay, activates; led flashes, steady after acknowledge
// R07: protection delay button toggles enable or cancels; led steady enabled, flashing counting
// R08: protection fault led flashes on fault, steady on disable or test
// R09: sounder delay button toggles enable or cancels; led steady enabled, flashing counting
// R10: sounder fault led flashes on fault, steady on disable or test
// R11: programmable button starts or stops group; led steady active, flashing while delayed
// R12: supply fault led flashes on battery fault, steady on mains or fuse fault (no fuse input; steady on mains fault only)
// R13: earth fault led lights on earth isolation fault
// R14: low battery led lights when on battery with insufficient charge
// R15: system fault led lights on system failure or event count above limit
// R16: sounder button silences if led on, else activates when manual start allowed
// R17: sounder led steady when active, flashing while delayed, off when off
// R18: sounder button may be ignored while sounder delay counts after first alarm
// R19: sounder led follows commanded state at once
// R20: panel reset clears event limit fault and restarts event counts
// R21: routing on led flashes once routed, steady after remote acknowledge
// R22: every flashing led uses one shared blink generator
// R23: delays counted by seconds tick, reloaded from configured value at start
`ifndef PIDC_DEFINES_SVH
`define PIDC_DEFINES_SVH
`define PIDC_CLK_HZ       100000000
`define PIDC_TICK_CYCLES  (`PIDC_CLK_HZ)
`define PIDC_BLINK_HALF_MS 500
`define PIDC_BLINK_CYCLES ((`PIDC_CLK_HZ / 1000) * `PIDC_BLINK_HALF_MS)
`define PIDC_EVT_LIMIT    10'h200
// register indices (word addresses)
`define PIDC_A_CTRL       4'h0
`define PIDC_A_RDLY       4'h1
`define PIDC_A_PDLY       4'h2
`define PIDC_A_SDLY       4'h3
`define PIDC_A_GDLY       4'h4
`define PIDC_A_STAT       4'h5
`define PIDC_A_RCNT       4'h6
`define PIDC_A_EVT        4'h7
`endif

// ===== rtl/pidc_pkg.sv
// types shared by the panel indicator block
// assumes nothing beyond the defines header
package pidc_pkg;
  typedef enum logic [1:0]
  {
    PIDC_IDLE  = 2'b00,
    PIDC_COUNT = 2'b01,
    PIDC_ON    = 2'b10,
    PIDC_ACK   = 2'b11
  } pidc_ch_t;
endpackage

// ===== rtl/pidc_top.sv
// panel indicator and delay control: buttons, delays, leds, countdown display
// assumes button pins and fault inputs are asynchronous; register port on clock_i
`timescale 1ns/10ps
`include "pidc_defines.svh"
module pidc_top #(
  parameter int unsigned TICK_CYCLES  = `PIDC_TICK_CYCLES,
  parameter int unsigned BLINK_CYCLES = `PIDC_BLINK_CYCLES,
  parameter int unsigned NTYPES       = 4
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // register port
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // front panel buttons (async pins, active high)
  input  wire logic              btn_route_dly_i,
  input  wire logic              btn_prot_on_i,
  input  wire logic              btn_prot_dly_i,
  input  wire logic              btn_snd_dly_i,
  input  wire logic              btn_group_i,
  input  wire logic              btn_snd_ss_i,
  // alarm, acknowledges and channel conditions (async)
  input  wire logic              alarm_i,
  input  wire logic              route_ack_i,
  input  wire logic              prot_ack_i,
  input  wire logic [2:0]        ch_fault_i,
  input  wire logic [2:0]        ch_dis_test_i,
  input  wire logic              batt_fault_i,
  input  wire logic              mains_fault_i,
  input  wire logic              earth_fault_i,
  input  wire logic              low_batt_i,
  input  wire logic              sys_fail_i,
  input  wire logic              manual_ok_i,
  input  wire logic              panel_reset_i,
  input  wire logic [NTYPES-1:0] evt_i,
  // leds
  output logic                   led_route_on_o,
  output logic                   led_route_dly_o,
  output logic                   led_route_fdt_o,
  output logic                   led_prot_on_o,
  output logic                   led_prot_dly_o,
  output logic                   led_prot_fdt_o,
  output logic                   led_snd_dly_o,
  output logic                   led_snd_fdt_o,
  output logic                   led_group_o,
  output logic                   led_supply_o,
  output logic                   led_earth_o,
  output logic                   led_low_batt_o,
  output logic                   led_sys_fault_o,
  output logic                   led_snd_ss_o,
  // outputs to the system and display
  output logic                   route_act_o,
  output logic                   prot_act_o,
  output logic                   snd_act_o,
  output logic                   group_act_o,
  output logic                   routing_stage_one_label_o,
  output logic                   routing_stage_two_label_o,
  output logic      [15:0]       disp_secs_o
);
  import pidc_pkg::*;

  localparam int NIN = 22 + NTYPES;

  // reset release through two flops
  logic rst_s1_reg, rst_reg;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i) begin rst_s1_reg <= 1'b0; rst_reg <= 1'b0; end
    else begin rst_s1_reg <= 1'b1; rst_reg <= rst_s1_reg; end
  end

  // two-flop synchronisers for every pin input, plus a third stage for edges
  logic [NIN-1:0] pin_raw, s1_reg, s2_reg, s3_reg;
  assign pin_raw = {evt_i, panel_reset_i, manual_ok_i, sys_fail_i, low_batt_i,
                    earth_fault_i, mains_fault_i, batt_fault_i, ch_dis_test_i,
                    ch_fault_i, prot_ack_i, route_ack_i, alarm_i, btn_snd_ss_i,
                    btn_group_i, btn_snd_dly_i, btn_prot_dly_i, btn_prot_on_i,
                    btn_route_dly_i};
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg) begin s1_reg <= '0; s2_reg <= '0; s3_reg <= '0; end
    else begin s1_reg <= pin_raw; s2_reg <= s1_reg; s3_reg <= s2_reg; end
  end
  logic [5:0] press;
  assign press = s2_reg[5:0] & ~s3_reg[5:0];
  logic alarm_s, rack_s, pack_s, manual_s, preset_rise;
  logic [2:0] fault_s, dt_s;
  logic [NTYPES-1:0] evt_rise;
  assign alarm_s     = s2_reg[6];
  assign rack_s      = s2_reg[7];
  assign pack_s      = s2_reg[8];
  assign fault_s     = s2_reg[11:9];
  assign dt_s        = s2_reg[14:12];
  assign manual_s    = s2_reg[20];
  assign preset_rise = s2_reg[21] & ~s3_reg[21];
  assign evt_rise    = s2_reg[NIN-1:22] & ~s3_reg[NIN-1:22];

  // shared seconds tick and blink phase
  logic [31:0] tick_cnt_reg, blink_cnt_reg;
  logic        sec_tick, blink_reg;
  assign sec_tick = (tick_cnt_reg == TICK_CYCLES - 1);
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg) tick_cnt_reg <= '0;
    else tick_cnt_reg <= sec_tick ? '0 : tick_cnt_reg + 32'h1; // R23
  end
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg) begin blink_cnt_reg <= '0; blink_reg <= 1'b0; end
    else if (blink_cnt_reg == BLINK_CYCLES - 1)
    begin
      blink_cnt_reg <= '0;
      blink_reg     <= ~blink_reg; // R22
    end
    else blink_cnt_reg <= blink_cnt_reg + 32'h1;
  end

  // software registers: ctrl = delay configured bits and extend bit
  logic [7:0]  ctrl_reg;
  logic [15:0] rdly_reg, pdly_reg, sdly_reg, gdly_reg;
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      ctrl_reg <= 8'h00;
      rdly_reg <= 16'h0000;
      pdly_reg <= 16'h0000;
      sdly_reg <= 16'h0000;
      gdly_reg <= 16'h0000;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `PIDC_A_CTRL: ctrl_reg <= reg_wdata_i[7:0];
        `PIDC_A_RDLY: rdly_reg <= reg_wdata_i[15:0];
        `PIDC_A_PDLY: pdly_reg <= reg_wdata_i[15:0];
        `PIDC_A_SDLY: sdly_reg <= reg_wdata_i[15:0];
        `PIDC_A_GDLY: gdly_reg <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // channel 0 routing, 1 protection, 2 sounder, 3 group
  pidc_ch_t    st_reg  [4];
  logic [15:0] rem_reg [4];
  logic [3:0]  en_reg;
  logic [3:0]  cfg;
  logic [15:0] dly [4];
  assign cfg = ctrl_reg[3:0];
  assign dly[0] = rdly_reg;
  assign dly[1] = pdly_reg;
  assign dly[2] = sdly_reg;
  assign dly[3] = gdly_reg;

  // per-channel start/cancel/stop requests
  logic [3:0] dly_btn, go_now, stop_req, start_req;
  logic       snd_led_on;
  assign snd_led_on = (st_reg[2] != PIDC_IDLE);
  assign dly_btn  = {1'b0, press[3], press[2], press[0]};
  assign go_now   = {1'b0, 1'b0, press[1], 1'b0}; // R06
  // sounder button: silence when lit unless blocked while counting
  assign stop_req = {press[4] & (st_reg[3] != PIDC_IDLE),
                     press[5] & snd_led_on & (st_reg[2] != PIDC_COUNT), // R16 R18
                     2'b00};
  assign start_req = {press[4] & (st_reg[3] == PIDC_IDLE), // R11
                      press[5] & ~snd_led_on & manual_s, // R16
                      alarm_s & (st_reg[1] == PIDC_IDLE),
                      alarm_s & (st_reg[0] == PIDC_IDLE)};

  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg) en_reg <= 4'h0;
    else
      for (int i = 0; i < 3; i++)
        if (dly_btn[i] && st_reg[i] != PIDC_COUNT)
          en_reg[i] <= ~en_reg[i]; // R01 R07 R09
  end

  generate
    for (genvar c = 0; c < 4; c++)
    begin : g_ch
      logic use_dly;
      assign use_dly = (c == 3) ? cfg[3] : (cfg[c] & en_reg[c]);
      always_ff @(posedge clock_i or negedge rst_reg)
      begin
        if (!rst_reg)
        begin
          st_reg[c]  <= PIDC_IDLE;
          rem_reg[c] <= 16'h0000;
        end
        else if (preset_rise)
          st_reg[c] <= PIDC_IDLE;
        else
        begin
          case (st_reg[c])
            PIDC_IDLE:
              if (go_now[c]) st_reg[c] <= PIDC_ON;
              else if (start_req[c] && use_dly && dly[c] != 16'h0000)
              begin
                st_reg[c]  <= PIDC_COUNT;
                rem_reg[c] <= dly[c]; // R23
              end
              else if (start_req[c]) st_reg[c] <= PIDC_ON;
            PIDC_COUNT:
              // on-button or delay button cancels the countdown
              if (go_now[c] || (dly_btn[c] && c != 3))
                st_reg[c] <= PIDC_ON; // R01 R07 R09
              else if (stop_req[c]) st_reg[c] <= PIDC_IDLE;
              else if (sec_tick)
              begin
                if (rem_reg[c] <= 16'h0001) st_reg[c] <= PIDC_ON; // R02
                rem_reg[c] <= rem_reg[c] - 16'h0001;
              end
            PIDC_ON:
              if (stop_req[c]) st_reg[c] <= PIDC_IDLE; // R19
              else if ((c == 0 && rack_s) || (c == 1 && pack_s))
                st_reg[c] <= PIDC_ACK; // R21 R06
            PIDC_ACK:
              if (stop_req[c]) st_reg[c] <= PIDC_IDLE;
            default: st_reg[c] <= PIDC_IDLE;
          endcase
        end
      end
    end
  endgenerate

  // event counters per type with limit flag
  logic [9:0] evt_cnt_reg [NTYPES];
  logic       ovf_reg;
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      for (int i = 0; i < NTYPES; i++) evt_cnt_reg[i] <= 10'h000;
      ovf_reg <= 1'b0;
    end
    else if (preset_rise)
    begin
      for (int i = 0; i < NTYPES; i++) evt_cnt_reg[i] <= 10'h000; // R20
      ovf_reg <= 1'b0;
    end
    else
      for (int i = 0; i < NTYPES; i++)
        if (evt_rise[i])
        begin
          if (evt_cnt_reg[i] == `PIDC_EVT_LIMIT) ovf_reg <= 1'b1; // R15
          else evt_cnt_reg[i] <= evt_cnt_reg[i] + 10'h001;
        end
  end

  // led helpers
  function automatic logic fdt(input logic f, input logic d, input logic b);
    fdt = f ? b : d;
  endfunction
  logic [3:0] counting, active, acked;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      counting[i] = (st_reg[i] == PIDC_COUNT);
      active[i]   = (st_reg[i] == PIDC_ON) || (st_reg[i] == PIDC_ACK);
      acked[i]    = (st_reg[i] == PIDC_ACK);
    end
  end

  // registered leds
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      {led_route_on_o, led_route_dly_o, led_route_fdt_o, led_prot_on_o} <= 4'h0;
      {led_prot_dly_o, led_prot_fdt_o, led_snd_dly_o, led_snd_fdt_o} <= 4'h0;
      {led_group_o, led_supply_o, led_earth_o, led_low_batt_o} <= 4'h0;
      {led_sys_fault_o, led_snd_ss_o} <= 2'h0;
    end
    else
    begin
      led_route_on_o  <= acked[0] | (active[0] & blink_reg); // R21
      led_prot_on_o   <= acked[1] | (active[1] & blink_reg); // R06
      led_route_dly_o <= counting[0] ? blink_reg : (cfg[0] & en_reg[0]); // R02
      led_prot_dly_o  <= counting[1] ? blink_reg : (cfg[1] & en_reg[1]); // R07
      led_snd_dly_o   <= counting[2] ? blink_reg : (cfg[2] & en_reg[2]); // R09
      led_route_fdt_o <= fdt(fault_s[0], dt_s[0], blink_reg); // R05
      led_prot_fdt_o  <= fdt(fault_s[1], dt_s[1], blink_reg); // R08
      led_snd_fdt_o   <= fdt(fault_s[2], dt_s[2], blink_reg); // R10
      led_group_o     <= counting[3] ? blink_reg : active[3]; // R11
      led_supply_o    <= s2_reg[16] | (s2_reg[15] & blink_reg); // R12
      led_earth_o     <= s2_reg[17]; // R13
      led_low_batt_o  <= s2_reg[18]; // R14
      led_sys_fault_o <= s2_reg[19] | ovf_reg; // R15
      led_snd_ss_o    <= counting[2] ? blink_reg : active[2]; // R17 R19
    end
  end

  // activations and display
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg)
    begin
      {route_act_o, prot_act_o, snd_act_o, group_act_o} <= 4'h0;
      routing_stage_one_label_o <= 1'b0;
      routing_stage_two_label_o <= 1'b0;
      disp_secs_o <= 16'h0000;
    end
    else
    begin
      {group_act_o, snd_act_o, prot_act_o, route_act_o} <= active;
      routing_stage_one_label_o <= counting[0] & ~ctrl_reg[4]; // R03
      routing_stage_two_label_o <= counting[0] & ctrl_reg[4]; // R04
      disp_secs_o <= counting[0] ? rem_reg[0] : 16'h0000;
    end
  end

  // register read, data one cycle after strobe
  always_ff @(posedge clock_i or negedge rst_reg)
  begin
    if (!rst_reg) reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PIDC_A_CTRL: reg_rdata_o <= {24'h000000, ctrl_reg};
        `PIDC_A_RDLY: reg_rdata_o <= {16'h0000, rdly_reg};
        `PIDC_A_PDLY: reg_rdata_o <= {16'h0000, pdly_reg};
        `PIDC_A_SDLY: reg_rdata_o <= {16'h0000, sdly_reg};
        `PIDC_A_GDLY: reg_rdata_o <= {16'h0000, gdly_reg};
        `PIDC_A_STAT: reg_rdata_o <= {15'h0000, ovf_reg, en_reg, 4'h0,
                                      st_reg[3], st_reg[2], st_reg[1], st_reg[0]};
        `PIDC_A_RCNT: reg_rdata_o <= {16'h0000, rem_reg[0]};
        `PIDC_A_EVT:  reg_rdata_o <= {22'h000000, evt_cnt_reg[0]};
        default:      reg_rdata_o <= 32'h0000_0000;
      endcase
    end
    else reg_rdata_o <= 32'h0000_0000;
  end

  // checks
  route_led_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R02
    counting[0] |=> led_route_dly_o == $past(blink_reg))
    else $error("routing delay led not flashing while counting");
  stage_lbl_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R04
    !(routing_stage_one_label_o && routing_stage_two_label_o))
    else $error("both routing labels shown");
  prot_go_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R06
    press[1] && !preset_rise |=> active[1])
    else $error("protection not active after on press");
  earth_led_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R13
    s2_reg[17] |=> led_earth_o)
    else $error("earth led missing");
  sys_fault_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R15
    ovf_reg |=> led_sys_fault_o)
    else $error("system fault led missing on overflow");
  reset_clr_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R20
    preset_rise |=> !ovf_reg)
    else $error("panel reset left overflow");
  snd_led_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R17
    active[2] |=> led_snd_ss_o)
    else $error("sounder led not steady while active");
  snd_block_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R18
    counting[2] && press[5] && !sec_tick && !preset_rise && !press[3] |=> counting[2])
    else $error("sounder silenced while delay counting");
  route_cancel_a: assert property (@(posedge clock_i) disable iff (!rst_reg) // R01
    press[0] && counting[0] && !preset_rise |=> active[0])
    else $error("routing delay not cancelled by button");
  cnt_route_c: cover property (@(posedge clock_i) disable iff (!rst_reg) counting[0]);
  cnt_snd_c:   cover property (@(posedge clock_i) disable iff (!rst_reg) counting[2]);
  cnt_grp_c:   cover property (@(posedge clock_i) disable iff (!rst_reg) counting[3]);
  ack_route_c: cover property (@(posedge clock_i) disable iff (!rst_reg) acked[0]);
  snd_on_c:    cover property (@(posedge clock_i) disable iff (!rst_reg) active[2]);
endmodule

// ===== dv/pidc_partner.sv
// remote monitoring model: acknowledges routing and protection signals
// assumes activation levels from the panel block on the bench clock
`timescale 1ns/10ps
module pidc_partner #(
  parameter int ACK_DLY = 12
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // activation seen and answer gate
  input  wire logic route_act_i,
  input  wire logic prot_act_i,
  input  wire logic ack_en_i,
  // acknowledges back to the panel
  output logic      route_ack_o,
  output logic      prot_ack_o
);
  int rcnt;
  int pcnt;
  // count time since activation, only while answering is allowed
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rcnt <= 0;
      pcnt <= 0;
    end
    else
    begin
      rcnt <= (route_act_i && ack_en_i) ? rcnt + 1 : 0;
      pcnt <= (prot_act_i && ack_en_i) ? pcnt + 1 : 0;
    end
  end
  // ack drops one cycle after the activation or the answer gate drops
  assign route_ack_o = rcnt > ACK_DLY;
  assign prot_ack_o  = pcnt > ACK_DLY;
endmodule

// ===== dv/pidc_top_tb.sv
// self-checking bench for the panel indicator and delay block
// assumes short tick and blink counts; partner answers acknowledges
`timescale 1ns/10ps
`include "pidc_defines.svh"
module pidc_top_tb;
  import pidc_pkg::*;
  localparam int TICK  = 10;
  localparam int BLINK = 4;
  typedef struct {int kind; int idx; logic [31:0] seen; logic [31:0] exp;} pidc_note_t;
  logic        clock_i;
  logic        rst_n_i;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_wr_i, reg_rd_i, rd_pend, busy;
  logic [31:0] reg_rdata_o, ones;
  logic [5:0]  btn;
  logic [2:0]  ch_fault, ch_dis;
  logic [4:0]  sup;
  logic [3:0]  evt;
  logic        alarm, ack_en, route_ack, prot_ack, manual_ok, panel_reset;
  // obs: 0..13 leds, 14..17 act outputs, 18..19 labels
  logic [19:0] obs;
  logic [15:0] disp;
  logic [15:0] lf = 16'h7f0f;
  pidc_note_t  q[$];
  pidc_note_t  m;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          d;
  int          t0;
  int          fdt[3] = '{2, 5, 7};
  int          sled[5] = '{9, 9, 10, 11, 12};

  pidc_top #(.TICK_CYCLES(TICK), .BLINK_CYCLES(BLINK), .NTYPES(4)) i_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .btn_route_dly_i(btn[0]), .btn_prot_on_i(btn[1]),
    .btn_prot_dly_i(btn[2]), .btn_snd_dly_i(btn[3]), .btn_group_i(btn[4]),
    .btn_snd_ss_i(btn[5]), .alarm_i(alarm), .route_ack_i(route_ack),
    .prot_ack_i(prot_ack), .ch_fault_i(ch_fault), .ch_dis_test_i(ch_dis),
    .batt_fault_i(sup[0]), .mains_fault_i(sup[1]), .earth_fault_i(sup[2]),
    .low_batt_i(sup[3]), .sys_fail_i(sup[4]), .manual_ok_i(manual_ok),
    .panel_reset_i(panel_reset), .evt_i(evt), .led_route_on_o(obs[0]),
    .led_route_dly_o(obs[1]), .led_route_fdt_o(obs[2]), .led_prot_on_o(obs[3]),
    .led_prot_dly_o(obs[4]), .led_prot_fdt_o(obs[5]), .led_snd_dly_o(obs[6]),
    .led_snd_fdt_o(obs[7]), .led_group_o(obs[8]), .led_supply_o(obs[9]),
    .led_earth_o(obs[10]), .led_low_batt_o(obs[11]), .led_sys_fault_o(obs[12]),
    .led_snd_ss_o(obs[13]), .route_act_o(obs[14]), .prot_act_o(obs[15]),
    .snd_act_o(obs[16]), .group_act_o(obs[17]), .routing_stage_one_label_o(obs[18]),
    .routing_stage_two_label_o(obs[19]), .disp_secs_o(disp));

  pidc_partner #(.ACK_DLY(12)) i_partner (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .route_act_i(obs[14]),
    .prot_act_i(obs[15]), .ack_en_i(ack_en), .route_ack_o(route_ack),
    .prot_ack_o(prot_ack));

  // clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // pseudo random source
  function automatic logic [15:0] lfsr();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // settle, note, then wait until the monitor has judged it
  task automatic note(input int k, input int i, input logic [31:0] s, input logic [31:0] e);
    cyc(6);
    q.push_back('{k, i, s, e});
    do @(posedge clock_i); while (q.size() != 0 || busy);
  endtask

  // e: highs seen in one blink period, 8 steady, 4 flashing, 0 off
  task automatic led(input int i, input int e);
    note(1, i, 32'h0, e);
  endtask

  task automatic ok(input logic s);
    note(2, 0, {31'h0, s}, 32'h1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    cyc(1);
    reg_wr_i <= 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back('{0, 0, 32'h0, e});
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    cyc(1);
    reg_rd_i <= 1'b0;
    cyc(2);
  endtask

  task automatic press(input int b);
    btn[b] <= 1'b1;
    cyc(4);
    btn[b] <= 1'b0;
    cyc(6);
  endtask

  task automatic preset();
    alarm       <= 1'b0;
    ack_en      <= 1'b0;
    panel_reset <= 1'b1;
    cyc(4);
    panel_reset <= 1'b0;
    cyc(4);
  endtask

  task automatic pulse();
    evt[0] <= 1'b1;
    cyc(2);
    evt[0] <= 1'b0;
    cyc(2);
  endtask

  task automatic wait_hi(input int i);
    for (int k = 0; k < 400 && obs[i] !== 1'b1; k++)
      cyc(1);
  endtask

  // monitor: judges the oldest note when its result appears
  always @(posedge clock_i) rd_pend <= reg_rd_i;
  initial
  begin
    busy = 1'b0;
    forever
    begin
      @(negedge clock_i);
      if (rd_pend === 1'b1)
      begin
        m = q.pop_front();
        check(reg_rdata_o, m.exp);
      end
      else if (q.size() != 0 && q[0].kind != 0)
      begin
        busy = 1'b1;
        m = q.pop_front();
        ones = 32'h0;
        if (m.kind == 1)
          repeat (2 * BLINK)
          begin
            ones = ones + obs[m.idx];
            @(negedge clock_i);
          end
        check(m.kind == 1 ? ones : m.seen, m.exp);
        busy = 1'b0;
      end
    end
  end

  // stimulus
  initial
  begin
    {rst_n_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, btn} = '0;
    {ch_fault, ch_dis, sup, evt, alarm, ack_en, manual_ok, panel_reset} = '0;
    cyc(6);
    rst_n_i <= 1'b1;
    cyc(4);
    d = 16 + lfsr() % 8;
    for (int a = 1; a < 5; a++)
      wr(a[3:0], d);
    wr(`PIDC_A_CTRL, 32'h0f);
    wr(`PIDC_A_STAT, {16'h0, lfsr()});
    rd(`PIDC_A_RDLY, d);
    rd(`PIDC_A_CTRL, 32'h0f);
    rd(`PIDC_A_STAT, 32'h0);
    rd(4'h9, 32'h0);
    led(1, 0);
    press(0);
    led(1, 8);
    press(0);
    led(1, 0);
    press(0);
    // channel fault flashes, disable or test steady
    for (int i = 0; i < 3; i++)
    begin
      ch_fault <= 3'b001 << i;
      led(fdt[i], 4);
      ch_fault <= 3'h0;
      ch_dis   <= 3'b001 << i;
      led(fdt[i], 8);
      ch_dis <= 3'h0;
    end
    // supply, earth, battery and system indications
    for (int i = 0; i < 5; i++)
    begin
      sup <= 5'h01 << i;
      led(sled[i], i == 0 ? 4 : 8);
    end
    sup <= 5'h0;
    led(12, 0);
    // plain routing delay runs out, protection has no delay
    alarm <= 1'b1;
    t0 = cycles;
    led(1, 4);
    led(18, 8);
    led(19, 0);
    ok(disp >= 1 && disp <= d);
    led(3, 4);
    wait_hi(14);
    ok(cycles - t0 >= (d - 1) * TICK && cycles - t0 <= d * TICK + 12);
    led(0, 4);
    ack_en <= 1'b1;
    cyc(20);
    led(0, 8);
    led(3, 8);
    preset();
    led(14, 0);
    // extended routing delay, both delays cancelled by buttons
    wr(`PIDC_A_CTRL, 32'h1f);
    press(2);
    led(4, 8);
    alarm <= 1'b1;
    led(19, 8);
    led(18, 0);
    led(4, 4);
    press(1);
    led(15, 8);
    press(0);
    led(14, 8);
    preset();
    // sounder start and stop
    press(5);
    led(16, 0);
    manual_ok <= 1'b1;
    press(5);
    led(13, 8);
    led(16, 8);
    press(5);
    led(13, 0);
    press(3);
    led(6, 8);
    press(5);
    led(13, 4);
    press(5);
    led(6, 4);
    led(13, 4);
    press(3);
    led(13, 8);
    press(5);
    led(13, 0);
    press(3);
    led(6, 0);
    // delayed output group
    press(4);
    led(8, 4);
    led(17, 0);
    wait_hi(17);
    led(8, 8);
    press(4);
    led(8, 0);
    // event limit and its clearing
    repeat (512) pulse();
    rd(`PIDC_A_EVT, 32'h200);
    led(12, 0);
    pulse();
    led(12, 8);
    preset();
    led(12, 0);
    rd(`PIDC_A_EVT, 32'h0);
    summarize();
  end
endmodule
